// ### common/lsc_pkg.sv
// Constants, opcodes and state types of the sensor command unit
package lsc_pkg;
  // Register addresses (5-bit address field)
  localparam logic [4:0] ADDR_LEFT_OFS = 5'h00;
  localparam logic [4:0] ADDR_LEFT_GAIN = 5'h01;
  localparam logic [4:0] ADDR_CENTRE_OFS = 5'h02;
  localparam logic [4:0] ADDR_CENTRE_GAIN = 5'h03;
  localparam logic [4:0] ADDR_RIGHT_OFS = 5'h04;
  localparam logic [4:0] ADDR_RIGHT_GAIN = 5'h05;
  localparam logic [4:0] ADDR_MODE = 5'h1f;
  // Mode register fields
  localparam int SLEEP_BIT = 4;
  // Values after reset
  localparam logic [7:0] OFS_RESET = 8'h00;
  localparam logic [4:0] GAIN_RESET = 5'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  // Action opcodes
  localparam logic [7:0] MAIN_RESET_OP = 8'h1b;
  localparam logic [7:0] BEGIN_INTEGRATION_OP = 8'h08;
  localparam logic [7:0] SAMPLE_HOLD_OP = 8'h10;
  localparam logic [7:0] PIXEL_READOUT_OP = 8'h02;
  localparam logic [7:0] READOUT_ABORT_OP = 8'h19;
  localparam logic [7:0] SAMPLE_AND_READOUT_OP = 8'h12;
  localparam logic [7:0] SAMPLE_READOUT_RESTART_OP = 8'h16;
  // Register command prefixes in bits 7:5
  localparam logic [2:0] REGISTER_STORE_PFX = 3'h2;
  localparam logic [2:0] REGISTER_FETCH_PFX = 3'h3;
  // Cycle counts
  localparam int REG_FETCH_DELAY = 4;
  localparam int PIXEL_READ_DELAY = 44;
  localparam int PIXEL_RESET_CLKS = 22;
  localparam int BREAK_ZEROS = 10;
  localparam int PIPE_LAT = 3;
  localparam logic [5:0] REG_WAIT_LOAD = 6'(REG_FETCH_DELAY - PIPE_LAT);
  localparam logic [5:0] PIX_WAIT_LOAD = 6'(PIXEL_READ_DELAY - PIPE_LAT);
  localparam logic [4:0] PIX_RESET_LOAD = 5'(PIXEL_RESET_CLKS - 1);
  localparam logic [3:0] BREAK_LAST = 4'(BREAK_ZEROS - 1);
  // Pixel array
  localparam logic [6:0] LAST_PIXEL = 7'h65;
  localparam logic [6:0] CENTRE_FIRST = 7'h22;
  localparam logic [6:0] RIGHT_FIRST = 7'h44;
  localparam logic [5:0] GAIN_UNITY = 6'h20;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_DATA = 2'b01,
    RX_WAIT_HIGH = 2'b10
  } rx_state_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_DATA = 2'b01,
    TX_STOP = 2'b10
  } tx_state_t;

  typedef enum logic [1:0] {
    PR_IDLE = 2'b00,
    PR_REG_WAIT = 2'b01,
    PR_PIX_WAIT = 2'b10,
    PR_PIX_RUN = 2'b11
  } prod_state_t;
endpackage : lsc_pkg

// ### logic/linear_sensor_command_unit.sv
// Serial command interpreter and readout control of the linear sensor array

// Functional notes
// - Seven registers: offsets at 0x00/02/04, gains 0x01/03/05, mode 0x1f.
// - Offsets are 8-bit sign-magnitude, gains are 5-bit unsigned.
// - Zone offset is applied before zone gain, so gain scales offset too.
// - Sleep bit set puts device asleep, cleared gives normal operation.
// - Register store: opcode plus 5-bit address, then one data byte.
// - Register fetch 0x60+address sends stored value LSB first.
// - Fetched value starts 4 clocks after fetch byte is received.
// - 0x1b resets logic, aborts readout, resets integrators, drops samples.
// - 0x08 starts integration after a 22-clock pixel reset cycle.
// - 0x10 samples integrators into hold and resets the integrators on the same clock.
// - 0x02 sends pixels 0 to 101, framed 8-bit words LSB first.
// - First pixel word starts 44 clocks after readout byte is received.
// - 0x19 stops readout and integration, resets integrators, drops samples.
// - 0x12 acts as sample then pixel readout.
// - 0x16 acts as sample, readout and start with 22-clock reset cycle.
// - Ten or more zero input bits reinitialise the command byte tracker.
// - Bytes: low start bit, 8 data bits, input rising, output falling edge.
// - Continuous pixel output has exactly one stop bit between words.
// - Receive and transmit run independently; commands taken during readout.
module linear_sensor_command_unit
  import lsc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic serial_in,
  input wire logic [7:0] sampled_level,
  output logic serial_out,
  output logic [6:0] pixel_addr,
  output logic integrator_reset,
  output logic integrating,
  output logic sample_hold_pulse,
  output logic samples_held,
  output logic sleep_select
);

  // Offset before gain: sign-magnitude add, clamp, then scale by (32+g)/32
  function automatic logic [7:0] apply_zone(input logic [7:0] raw,
                                           input logic [7:0] ofs,
                                           input logic [4:0] gain);
    logic signed [9:0] sum;
    logic [7:0] lvl;
    logic [13:0] prod;
    sum = $signed({2'b00, raw});
    if (ofs[7]) begin
      sum = sum - $signed({3'b000, ofs[6:0]});
    end else begin
      sum = sum + $signed({3'b000, ofs[6:0]});
    end
    if (sum < 0) begin
      lvl = 8'h00;
    end else if (sum > 10'sd255) begin
      lvl = 8'hff;
    end else begin
      lvl = sum[7:0];
    end
    prod = lvl * (GAIN_UNITY + {1'b0, gain});
    apply_zone = (prod[13:5] > 9'h0ff) ? 8'hff : prod[12:5];
  endfunction : apply_zone

  logic [7:0] ofs_reg [3];
  logic [4:0] gain_reg [3];
  logic [7:0] operating_mode;

  // Register readback; unmapped addresses read zero
  function automatic logic [7:0] fetch_reg(input logic [4:0] a,
                                          input logic [7:0] o0,
                                          input logic [7:0] o1,
                                          input logic [7:0] o2,
                                          input logic [4:0] g0,
                                          input logic [4:0] g1,
                                          input logic [4:0] g2,
                                          input logic [7:0] m);
    case (a)
      ADDR_LEFT_OFS: fetch_reg = o0;
      ADDR_LEFT_GAIN: fetch_reg = {3'h0, g0};
      ADDR_CENTRE_OFS: fetch_reg = o1;
      ADDR_CENTRE_GAIN: fetch_reg = {3'h0, g1};
      ADDR_RIGHT_OFS: fetch_reg = o2;
      ADDR_RIGHT_GAIN: fetch_reg = {3'h0, g2};
      ADDR_MODE: fetch_reg = m;
      default: fetch_reg = 8'h00;
    endcase
  endfunction : fetch_reg

  rx_state_t rx_state;
  logic [3:0] rx_bit;
  logic [7:0] rx_shift;
  logic [3:0] zero_run;
  logic byte_valid;
  logic [7:0] rx_byte;
  logic store_pending;
  logic [4:0] store_addr;

  // Receiver: start bit, eight data bits on rising edge, stop optional
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_state <= RX_WAIT_HIGH;
      rx_bit <= 4'h0;
      rx_shift <= 8'h00;
      byte_valid <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      byte_valid <= 1'b0;
      if (!serial_in && zero_run == BREAK_LAST) begin
        rx_state <= RX_WAIT_HIGH;
      end else begin
        case (rx_state)
          RX_IDLE: begin
            if (!serial_in) begin
              rx_state <= RX_DATA;
              rx_bit <= 4'h0;
            end
          end
          RX_DATA: begin
            rx_shift <= {serial_in, rx_shift[7:1]};
            rx_bit <= rx_bit + 4'h1;
            if (rx_bit == 4'h7) begin
              rx_state <= RX_IDLE;
              byte_valid <= 1'b1;
              rx_byte <= {serial_in, rx_shift[7:1]};
            end
          end
          RX_WAIT_HIGH: begin
            if (serial_in) begin
              rx_state <= RX_IDLE;
            end
          end
          default: rx_state <= RX_WAIT_HIGH;
        endcase
      end
    end
  end

  // Break detector counts consecutive low input bits
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      zero_run <= 4'h0;
    end else if (serial_in) begin
      zero_run <= 4'h0;
    end else if (zero_run != BREAK_LAST) begin
      zero_run <= zero_run + 4'h1;
    end
  end

  // Command decode strobes
  logic is_cmd;
  logic do_reset;
  logic do_abort;
  logic do_start;
  logic do_sample;
  logic do_read;
  logic do_fetch;
  logic break_seen;
  assign is_cmd = byte_valid && !store_pending;
  assign break_seen = !serial_in && zero_run == BREAK_LAST;
  assign do_reset = is_cmd && rx_byte == MAIN_RESET_OP;
  assign do_abort = is_cmd && rx_byte == READOUT_ABORT_OP;
  assign do_start = is_cmd && (rx_byte == BEGIN_INTEGRATION_OP ||
                               rx_byte == SAMPLE_READOUT_RESTART_OP);
  assign do_sample = is_cmd && (rx_byte == SAMPLE_HOLD_OP ||
                                rx_byte == SAMPLE_AND_READOUT_OP ||
                                rx_byte == SAMPLE_READOUT_RESTART_OP);
  assign do_read = is_cmd && (rx_byte == PIXEL_READOUT_OP ||
                              rx_byte == SAMPLE_AND_READOUT_OP ||
                              rx_byte == SAMPLE_READOUT_RESTART_OP);
  assign do_fetch = is_cmd && rx_byte[7:5] == REGISTER_FETCH_PFX;

  // Two-byte register store: remember address, write on data byte
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      store_pending <= 1'b0;
      store_addr <= 5'h00;
    end else if (break_seen || do_reset) begin
      store_pending <= 1'b0;
    end else if (byte_valid) begin
      store_pending <= !store_pending &&
                       rx_byte[7:5] == REGISTER_STORE_PFX;
      store_addr <= rx_byte[4:0];
    end
  end

  // Register file; unknown addresses are dropped
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 3; i++) begin
        ofs_reg[i] <= OFS_RESET;
        gain_reg[i] <= GAIN_RESET;
      end
      operating_mode <= MODE_RESET;
    end else if (byte_valid && store_pending) begin
      case (store_addr)
        ADDR_LEFT_OFS: ofs_reg[0] <= rx_byte;
        ADDR_LEFT_GAIN: gain_reg[0] <= rx_byte[4:0];
        ADDR_CENTRE_OFS: ofs_reg[1] <= rx_byte;
        ADDR_CENTRE_GAIN: gain_reg[1] <= rx_byte[4:0];
        ADDR_RIGHT_OFS: ofs_reg[2] <= rx_byte;
        ADDR_RIGHT_GAIN: gain_reg[2] <= rx_byte[4:0];
        ADDR_MODE: operating_mode <= rx_byte;
        default: ;
      endcase
    end
  end
  assign sleep_select = operating_mode[SLEEP_BIT];

  // Integrator control: pixel reset cycle, integration, sample and hold
  logic [4:0] reset_cnt;
  logic reset_cycle;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      integrator_reset <= 1'b1;
      integrating <= 1'b0;
      sample_hold_pulse <= 1'b0;
      samples_held <= 1'b0;
      reset_cycle <= 1'b0;
      reset_cnt <= 5'h00;
    end else begin
      sample_hold_pulse <= do_sample;
      if (do_reset || do_abort) begin
        integrator_reset <= 1'b1;
        integrating <= 1'b0;
        samples_held <= 1'b0;
        reset_cycle <= 1'b0;
      end else begin
        if (do_sample) begin
          integrating <= 1'b0;
          integrator_reset <= 1'b1;
          samples_held <= 1'b1;
        end
        if (do_start) begin
          reset_cycle <= 1'b1;
          reset_cnt <= PIX_RESET_LOAD;
        end else if (reset_cycle) begin
          reset_cnt <= reset_cnt - 5'h01;
          if (reset_cnt == 5'h00) begin
            reset_cycle <= 1'b0;
            integrator_reset <= 1'b0;
            integrating <= 1'b1;
          end
        end
      end
    end
  end

  // Word producer feeding the two-entry buffer
  prod_state_t pr_state;
  logic [5:0] wait_cnt;
  logic [7:0] fetch_word;
  logic push;
  logic [7:0] push_word;
  logic buf_in_ready;
  logic [1:0] zone;
  logic kill;
  assign kill = do_reset || do_abort || break_seen;
  assign zone = pixel_addr < CENTRE_FIRST ? 2'd0 :
                pixel_addr < RIGHT_FIRST ? 2'd1 : 2'd2;
  assign push = buf_in_ready && ((pr_state == PR_REG_WAIT &&
                wait_cnt == 6'h00) || pr_state == PR_PIX_RUN);
  assign push_word = pr_state == PR_REG_WAIT ? fetch_word :
                     apply_zone(sampled_level, ofs_reg[zone],
                                gain_reg[zone]);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pr_state <= PR_IDLE;
      wait_cnt <= 6'h00;
      fetch_word <= 8'h00;
      pixel_addr <= 7'h00;
    end else if (kill) begin
      pr_state <= PR_IDLE;
      pixel_addr <= 7'h00;
    end else if (do_read) begin
      pr_state <= PR_PIX_WAIT;
      wait_cnt <= PIX_WAIT_LOAD;
      pixel_addr <= 7'h00;
    end else if (do_fetch) begin
      pr_state <= PR_REG_WAIT;
      wait_cnt <= REG_WAIT_LOAD;
      fetch_word <= fetch_reg(rx_byte[4:0], ofs_reg[0], ofs_reg[1],
                              ofs_reg[2], gain_reg[0], gain_reg[1],
                              gain_reg[2], operating_mode);
    end else begin
      case (pr_state)
        PR_IDLE: ;
        PR_REG_WAIT: begin
          if (wait_cnt != 6'h00) begin
            wait_cnt <= wait_cnt - 6'h01;
          end else if (push) begin
            pr_state <= PR_IDLE;
          end
        end
        PR_PIX_WAIT: begin
          wait_cnt <= wait_cnt - 6'h01;
          if (wait_cnt == 6'h01) begin
            pr_state <= PR_PIX_RUN;
          end
        end
        PR_PIX_RUN: begin
          if (push) begin
            if (pixel_addr == LAST_PIXEL) begin
              pr_state <= PR_IDLE;
              pixel_addr <= 7'h00;
            end else begin
              pixel_addr <= pixel_addr + 7'h01;
            end
          end
        end
        default: pr_state <= PR_IDLE;
      endcase
    end
  end

  // Two-entry buffer; a busy transmitter stalls the producer, no word lost
  logic [7:0] buf_mem [2];
  logic buf_wr;
  logic buf_rd;
  logic [1:0] buf_cnt;
  logic buf_out_valid;
  logic pop;
  assign buf_in_ready = buf_cnt != 2'd2;
  assign buf_out_valid = buf_cnt != 2'd0;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      buf_wr <= 1'b0;
      buf_rd <= 1'b0;
      buf_cnt <= 2'd0;
      buf_mem[0] <= 8'h00;
      buf_mem[1] <= 8'h00;
    end else if (kill) begin
      buf_wr <= 1'b0;
      buf_rd <= 1'b0;
      buf_cnt <= 2'd0;
    end else begin
      if (push) begin
        buf_mem[buf_wr] <= push_word;
        buf_wr <= !buf_wr;
      end
      if (pop) begin
        buf_rd <= !buf_rd;
      end
      buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, pop};
    end
  end

  // Transmitter, independent of the receiver; a new word is taken only in
  // idle, so the stop bit is never skipped and the next start follows it
  tx_state_t tx_state;
  logic [7:0] tx_shift;
  logic [2:0] tx_bit;
  logic tx_line;
  assign pop = buf_out_valid && tx_state == TX_IDLE;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_state <= TX_IDLE;
      tx_shift <= 8'h00;
      tx_bit <= 3'h0;
      tx_line <= 1'b1;
    end else if (kill) begin
      tx_state <= TX_IDLE;
      tx_line <= 1'b1;
    end else if (pop) begin
      tx_state <= TX_DATA;
      tx_shift <= buf_mem[buf_rd];
      tx_bit <= 3'h0;
      tx_line <= 1'b0;
    end else begin
      case (tx_state)
        TX_IDLE: tx_line <= 1'b1;
        TX_DATA: begin
          tx_line <= tx_shift[0];
          tx_shift <= {1'b0, tx_shift[7:1]};
          tx_bit <= tx_bit + 3'h1;
          if (tx_bit == 3'h7) begin
            tx_state <= TX_STOP;
          end
        end
        TX_STOP: begin
          tx_line <= 1'b1;
          tx_state <= TX_IDLE;
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // Output pin changes on the falling edge so the controller samples mid-bit
  always_ff @(negedge core_clk or posedge rst) begin
    if (rst) begin
      serial_out <= 1'b1;
    end else begin
      serial_out <= tx_line;
    end
  end

endmodule : linear_sensor_command_unit

// ### testbench/linear_sensor_command_unit_test.sv
// Self-checking bench of the sensor command unit
module linear_sensor_command_unit_test
  import lsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst, serial_in, serial_out;
  logic integrator_reset, integrating, sample_hold_pulse;
  logic samples_held, sleep_select, stop;
  logic [7:0] sampled_level, wd, lat;
  logic [6:0] pixel_addr;
  int miscompares = 0;
  int n_checks = 0;

  linear_sensor_command_unit linear_sensor_command_unit_i (
    .core_clk(core_clk), .rst(rst), .serial_in(serial_in),
    .sampled_level(sampled_level), .serial_out(serial_out),
    .pixel_addr(pixel_addr), .integrator_reset(integrator_reset),
    .integrating(integrating), .sample_hold_pulse(sample_hold_pulse),
    .samples_held(samples_held), .sleep_select(sleep_select));
  scan_controller scan_controller_i (.core_clk(core_clk),
    .serial_in(serial_in), .serial_out(serial_out));

  // 50 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  // Reply start bit lands five edges after the last command bit
  task automatic fetch(input logic [4:0] addr, input logic [7:0] exp);
    scan_controller_i.send_byte({REGISTER_FETCH_PFX, addr});
    scan_controller_i.get_word(20, wd, lat, stop);
    check("fetch delay", lat, 8'(REG_FETCH_DELAY + 1));
    check("fetch data", wd, exp);
    check("fetch stop", {7'h00, stop}, 8'h01);
    scan_controller_i.hold_line(1'b1, 5);
  endtask : fetch

  task automatic t_integrate();
    scan_controller_i.send_cmd(MAIN_RESET_OP);
    check("reset", {6'h00, integrator_reset, integrating}, 8'h02);
    scan_controller_i.send_byte(BEGIN_INTEGRATION_OP);
    scan_controller_i.hold_line(1'b1, PIXEL_RESET_CLKS);
    check("early", {6'h00, integrator_reset, integrating}, 8'h02);
    scan_controller_i.hold_line(1'b1, 1);
    check("start", {6'h00, integrator_reset, integrating}, 8'h01);
    scan_controller_i.send_byte(SAMPLE_HOLD_OP);
    scan_controller_i.hold_line(1'b1, 1);
    check("sample", {5'h00, sample_hold_pulse, samples_held, integrating},
          8'h06);
    scan_controller_i.hold_line(1'b1, 1);
    check("after", {5'h00, sample_hold_pulse, integrator_reset,
          samples_held}, 8'h03);
    scan_controller_i.hold_line(1'b1, 3);
    $display("integration test done");
  endtask : t_integrate

  // Gains written with upper bits set; an unmapped store is dropped
  task automatic t_regs();
    logic [7:0] put [6] = '{8'h05, 8'he0, 8'h84, 8'hf0, 8'h00, 8'hff};
    logic [7:0] back [6] = '{8'h05, 8'h00, 8'h84, 8'h10, 8'h00, 8'h1f};
    int i;
    for (i = 0; i < 6; i++) begin
      scan_controller_i.store_reg(5'(i), put[i]);
    end
    scan_controller_i.store_reg(5'h06, 8'haa);
    for (i = 0; i < 6; i++) begin
      fetch(5'(i), back[i]);
    end
    fetch(5'h06, 8'h00);
    scan_controller_i.store_reg(ADDR_MODE, 8'h10);
    check("sleep on", {7'h00, sleep_select}, 8'h01);
    fetch(ADDR_MODE, 8'h10);
    scan_controller_i.store_reg(ADDR_MODE, 8'h00);
    check("sleep off", {7'h00, sleep_select}, 8'h00);
    $display("register test done");
  endtask : t_regs

  // Raw level 0x40: left +5, centre -4 times 1.5, right times 63/32
  task automatic t_readout(input logic [7:0] op);
    int p;
    logic [7:0] exp;
    scan_controller_i.send_byte(op);
    for (p = 0; p < 102; p++) begin
      scan_controller_i.get_word(60, wd, lat, stop);
      exp = (p == 0) ? 8'(PIXEL_READ_DELAY + 1) : 8'h01;
      check("gap", lat, exp);
      exp = (p < 34) ? 8'h45 : (p < 68) ? 8'h5a : 8'h7e;
      check("pixel", wd, exp);
      check("pixel stop", {7'h00, stop}, 8'h01);
    end
    scan_controller_i.get_word(30, wd, lat, stop);
    check("after last", lat, 8'h00);
    check("addr idle", {1'b0, pixel_addr}, 8'h00);
    check("held", {7'h00, samples_held}, 8'h01);
    $display("readout test done");
  endtask : t_readout

  // Nine zeros form a byte, the tenth must resync the receiver
  task automatic t_break();
    scan_controller_i.hold_line(1'b0, BREAK_ZEROS);
    scan_controller_i.hold_line(1'b1, 2);
    fetch(ADDR_RIGHT_GAIN, 8'h1f);
    $display("break test done");
  endtask : t_break

  // Restart readout, then kill it while words are still going out
  task automatic t_abort(input logic [7:0] kill_op);
    scan_controller_i.send_byte(SAMPLE_READOUT_RESTART_OP);
    scan_controller_i.get_word(60, wd, lat, stop);
    check("restart gap", lat, 8'(PIXEL_READ_DELAY + 1));
    repeat (2) scan_controller_i.get_word(20, wd, lat, stop);
    check("restart integ", {7'h00, integrating}, 8'h01);
    scan_controller_i.send_cmd(kill_op);
    check("killed", {5'h00, integrator_reset, integrating, samples_held},
          8'h04);
    check("addr killed", {1'b0, pixel_addr}, 8'h00);
    scan_controller_i.get_word(60, wd, lat, stop);
    check("quiet", lat, 8'h00);
    $display("abort test done");
  endtask : t_abort

  // Main sequence
  initial begin
    rst = 1'b1;
    sampled_level = 8'h40;
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    scan_controller_i.power_up();
    t_integrate();
    t_regs();
    t_readout(SAMPLE_AND_READOUT_OP);
    t_readout(PIXEL_READOUT_OP);
    t_break();
    t_abort(READOUT_ABORT_OP);
    t_abort(MAIN_RESET_OP);
    conclude();
  end

  // The tests need about 3000 clocks; this allows more than three times
  initial begin
    #200000;
    miscompares++;
    conclude();
  end
endmodule : linear_sensor_command_unit_test

// ### testbench/lsc_properties.sv
// Port-level checks of the sensor command unit
module lsc_properties
  import lsc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic serial_in,
  input wire logic [7:0] sampled_level,
  input wire logic serial_out,
  input wire logic [6:0] pixel_addr,
  input wire logic integrator_reset,
  input wire logic integrating,
  input wire logic sample_hold_pulse,
  input wire logic samples_held,
  input wire logic sleep_select
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] frame_pos;
  logic [4:0] reset_run;

  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // Bit position inside an outgoing word, 0 while the line idles
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      frame_pos <= 4'h0;
    end else if (frame_pos == 4'h0) begin
      frame_pos <= serial_out ? 4'h0 : 4'h1;
    end else begin
      frame_pos <= (frame_pos == 4'h9) ? 4'h0 : frame_pos + 4'h1;
    end
  end

  // Saturating run of cycles with the integrators held in reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reset_run <= 5'h00;
    end else if (!integrator_reset) begin
      reset_run <= 5'h00;
    end else if (reset_run != 5'h1f) begin
      reset_run <= reset_run + 5'h01;
    end
  end

  integ_excl_a: assert property (integrating |-> !integrator_reset)
    else $error("integrating while integrators held in reset");
  // One cycle of slack: a restart may raise reset only at the sample edge
  integ_wait_a: assert property (
      $rose(integrating) |-> reset_run >= 5'd21)
    else $error("integration began before the pixel reset cycle");
  pulse_single_a: assert property (
      sample_hold_pulse |=> !sample_hold_pulse)
    else $error("sample pulse longer than one cycle");
  pulse_effect_a: assert property (sample_hold_pulse |->
      ##[0:1] (samples_held && integrator_reset && !integrating))
    else $error("sample left integrators out of reset or nothing held");
  stop_bit_a: assert property (frame_pos == 4'h9 |-> serial_out)
    else $error("output word lacks its stop bit");
  addr_range_a: assert property (pixel_addr <= LAST_PIXEL)
    else $error("pixel address beyond last pixel");
  addr_step_a: assert property ($changed(pixel_addr) |->
      pixel_addr == $past(pixel_addr) + 7'h01 || pixel_addr == 7'h00)
    else $error("pixels not converted in order");
  // Buffer and transmitter take three words at once, then one per frame
  addr_pace_a: assert property ($changed(pixel_addr) &&
      pixel_addr > 7'h02 |=> $stable(pixel_addr) [*8])
    else $error("pixel advanced faster than one word");
endmodule : lsc_properties

bind linear_sensor_command_unit lsc_properties lsc_properties_i (
  .core_clk(core_clk), .rst(rst), .serial_in(serial_in),
  .sampled_level(sampled_level), .serial_out(serial_out),
  .pixel_addr(pixel_addr), .integrator_reset(integrator_reset),
  .integrating(integrating), .sample_hold_pulse(sample_hold_pulse),
  .samples_held(samples_held), .sleep_select(sleep_select)
);

// ### testbench/scan_controller.sv
// Behavioural scanner controller on the far side of the serial link
module scan_controller
  import lsc_pkg::*;
(
  input wire logic core_clk,
  output logic serial_in,
  input wire logic serial_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Line idles high so no false start bit is seen
  initial begin
    serial_in = 1'b1;
  end

  // Holds the input line at one level for a number of clocks
  task automatic hold_line(input logic level, input int clocks);
    repeat (clocks) begin
      @(negedge core_clk);
      serial_in = level;
    end
  endtask : hold_line

  // Start bit, data LSB first, stop bit; returns just after the last bit
  task automatic send_byte(input logic [7:0] b);
    int i;
    @(negedge core_clk);
    serial_in = 1'b0;
    for (i = 0; i < 8; i++) begin
      @(negedge core_clk);
      serial_in = b[i];
    end
    @(negedge core_clk);
    serial_in = 1'b1;
  endtask : send_byte

  // Command with the settling clocks the device needs
  task automatic send_cmd(input logic [7:0] op);
    send_byte(op);
    hold_line(1'b1, 5);
  endtask : send_cmd

  // Store: opcode carrying the address, then the data byte
  task automatic store_reg(input logic [4:0] addr, input logic [7:0] data);
    send_byte({REGISTER_STORE_PFX, addr});
    send_byte(data);
    hold_line(1'b1, 5);
  endtask : store_reg

  // Idle high, three main resets, then wait for the output to settle
  task automatic power_up();
    hold_line(1'b1, 10);
    repeat (3) send_cmd(MAIN_RESET_OP);
    hold_line(1'b1, 30);
  endtask : power_up

  // Waits for a start bit; lat is clocks waited, 0 when none came
  task automatic get_word(input int limit, output logic [7:0] w,
                          output logic [7:0] lat, output logic stop);
    int n;
    lat = 8'h00;
    w = 8'h00;
    stop = 1'b0;
    for (n = 1; n <= limit; n++) begin
      @(posedge core_clk);
      if (serial_out === 1'b0) begin
        lat = 8'(n);
        break;
      end
    end
    if (lat != 8'h00) begin
      for (n = 0; n < 8; n++) begin
        @(posedge core_clk);
        w[n] = serial_out;
      end
      @(posedge core_clk);
      stop = serial_out;
    end
  endtask : get_word
endmodule : scan_controller
